// ### hw/ptm_map.vh
// Register map, field positions, reset values and mode codes of the period timer.
// Assumes inclusion by bare name from every design file of the timer except the synchroniser.
`ifndef PTM_MAP_VH
`define PTM_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PTM_ADR_COUNT 8'h00
`define PTM_ADR_PERIOD 8'h04
`define PTM_ADR_CTL 8'h08
`define PTM_ADR_CTL1 8'h0C
`define PTM_ADR_HALT 8'h10
`define PTM_ADR_RSEL 8'h14
`define PTM_ADR_STAT 8'h18

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTM_COUNT_RST 8'h00
`define PTM_PERIOD_RST 8'hFF
`define PTM_BYTE_ZERO 8'h00
`define PTM_POST_ZERO 5'h00
`define PTM_PRE_ZERO 7'h00
`define PTM_WORD_ZERO 32'h0000_0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PTM_CTL_ON 7
`define PTM_CTL_CKSRC 3
`define PTM_CTL_PRE_HI 2
`define PTM_CTL_PRE_LO 0
`define PTM_C1_PS_HI 4
`define PTM_C1_PS_LO 0
`define PTM_HLT_MAJ_HI 4
`define PTM_HLT_MAJ_LO 3
`define PTM_HLT_OPT_HI 2
`define PTM_HLT_OPT_LO 0
`define PTM_RSEL_HI 1
`define PTM_RSEL_LO 0

// ----------------------------------------------------------------
// Operation-select mapping table
// ----------------------------------------------------------------
`define PTM_MAJ_FREE 2'h0
`define PTM_MAJ_ONESHOT 2'h1
`define PTM_MAJ_MONO 2'h2
`define PTM_OPT_SW 3'h0
`define PTM_OPT_GATE_HI 3'h1
`define PTM_OPT_GATE_LO 3'h2
`define PTM_OPT_RST_RISE 3'h3
`define PTM_OPT_RST_FALL 3'h4
`define PTM_OPT_RST_BOTH 3'h5
`define PTM_OPT_RST_HI 3'h6
`define PTM_OPT_RST_LO 3'h7

`endif

// ### hw/ptm_sync.v
// Three-stage synchroniser for one pin input with agreement filter.
// Assumes an asynchronous input and the single system clock.
`timescale 1ns/1ps
`default_nettype none

module ptm_sync (
	input wire clk_i,
	input wire rst_i,
	input wire pin_i,
	output reg level_o
);

	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	// First stage is read only by the second; output moves when stages two and three agree
	always @(posedge clk_i) begin
		if (rst_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_o <= 1'b0;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				level_o <= s3_ff;
			end
		end
	end

endmodule // ptm_sync

`default_nettype wire

// ### hw/ptm_prescale.v
// Programmable prescaler: divides source ticks by 1 to 128 in powers of two.
// Assumes en_i and clr_i are single-cycle qualifiers on the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.vh"

module ptm_prescale (
	input wire clk_i,
	input wire rst_i,
	input wire en_i,
	input wire clr_i,
	input wire [2:0] ratio_i,
	output wire tick_o
);

	reg [6:0] cnt_ff;
	wire [6:0] limit;

	// Terminal count is 2^ratio minus one
	assign limit = (7'h01 << ratio_i) - 7'h01;
	assign tick_o = en_i && !clr_i && (cnt_ff == limit);

	// Clear has priority so a timer reset restarts the division from zero
	always @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			cnt_ff <= `PTM_PRE_ZERO;
		end else if (en_i) begin
			if (cnt_ff >= limit) begin
				cnt_ff <= `PTM_PRE_ZERO;
			end else begin
				cnt_ff <= cnt_ff + 7'h01;
			end
		end
	end

endmodule // ptm_prescale

`default_nettype wire

// ### hw/ptm_top.v
// Period timer with prescaler, period match, postscaler and external reset/gate source.
// Assumes a classic Wishbone master on clk_i and asynchronous trigger pins.
// How it works
// - Three major modes: free-running period, one-shot, monostable, each with start/stop/reset options.
// - Count advances once per prescaler output tick in every mode.
// - Count equal to period drives match high; next timer tick clears count.
// - Gated options freeze the count while gate inactive, resume from held value.
// - Reset options clear the count on a source level or edge.
// - Count and period readable and writable; reset gives count 00h, period FFh.
// - Count write, control write, reset or reset event clear both scalers; control write keeps count.
// - Free-running: match sets count 00h next tick and advances postscaler.
// - Postscaler equal to select field emits a pulse lasting to the next tick or timer stop, and clears postscaler.
// - One-shot: match clears the run flag and stops until software sets it again.
// - One-shot restart clears postscaler, so nonzero postscale selects are useless.
// - Monostable: match stops, run flag kept; external reset event restarts.
// - Per-timer select register picks the external source that starts, stops or resets.
// - Five-bit operation-select field in halt control register sets mode and options.
// - Debug freeze holds the selected reset/gate source level; the clock pin still counts.
// - Postscaled pulse feeds converter trigger and output-generator shutdown.
// - Live count and period-match signals go to the PWM unit.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.vh"

module ptm_top (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire [3:0] ext_src_i,
	input wire ext_clk_i,
	input wire dbg_freeze_i,
	output reg postscaled_pulse_out_o,
	output reg adc_trigger_o,
	output reg shutdown_src_o,
	output reg [7:0] timer_count_o,
	output reg period_match_o,
	output reg timer_tick_o
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [7:0] count_ff;
	reg [7:0] period_ff;
	reg [7:0] ctl_ff;
	reg [4:0] ctl1_ff;
	reg [4:0] halt_ff;
	reg [1:0] rsel_ff;
	reg [4:0] post_ff;
	reg stopped_ff;
	reg ext_hold_ff;
	reg ext_prev_ff;
	reg ck_prev_ff;
	reg [7:0] nxt_count;
	reg [4:0] nxt_post;
	reg nxt_on;
	reg nxt_stopped;

	wire [4:0] sync_lvl;
	wire [4:0] pin_bus;
	wire bus_req;
	wire bus_wr;
	wire wr_byte;
	wire wr_count;
	wire wr_ctl;
	wire [1:0] maj;
	wire [2:0] opt;
	wire on_bit;
	wire ext_now;
	wire ext_rise;
	wire ext_fall;
	wire gate_ok;
	wire lvl_rst;
	wire edge_rst;
	wire rst_ev;
	wire scaler_clr;
	wire run;
	wire src_en;
	wire tick;
	wire eq;
	wire match;
	wire post_hit;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Four reset sources plus the external timer clock pin in the top lane
	assign pin_bus = {ext_clk_i, ext_src_i};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
			ptm_sync u_sync (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.pin_i(pin_bus[gi]),
				.level_o(sync_lvl[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// One-cycle ack; writes use the low byte lane, status reads return bits 8:0
	assign bus_req = cyc_i && stb_i && !ack_o;
	assign bus_wr = bus_req && we_i;
	assign wr_byte = bus_wr && sel_i[0];
	assign wr_count = wr_byte && (adr_i == `PTM_ADR_COUNT);
	assign wr_ctl = wr_byte && (adr_i == `PTM_ADR_CTL);

	// ----------------------------------------------------------------
	// Mode decode and external source
	// ----------------------------------------------------------------
	assign maj = halt_ff[`PTM_HLT_MAJ_HI:`PTM_HLT_MAJ_LO];
	assign opt = halt_ff[`PTM_HLT_OPT_HI:`PTM_HLT_OPT_LO];
	assign on_bit = ctl_ff[`PTM_CTL_ON];
	assign ext_now = sync_lvl[rsel_ff];

	// Source level is held during debug freeze so no gate change or edge is seen
	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_hold_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
			ck_prev_ff <= 1'b0;
		end else begin
			if (!dbg_freeze_i) begin
				ext_hold_ff <= ext_now;
			end
			ext_prev_ff <= ext_hold_ff;
			ck_prev_ff <= sync_lvl[4];
		end
	end

	assign ext_rise = ext_hold_ff && !ext_prev_ff;
	assign ext_fall = !ext_hold_ff && ext_prev_ff;

	// Gate options halt counting without touching the held count
	assign gate_ok = (opt == `PTM_OPT_GATE_HI) ? ext_hold_ff :
		(opt == `PTM_OPT_GATE_LO) ? !ext_hold_ff : 1'b1;

	// Level resets hold the timer clear for as long as the level stands
	assign lvl_rst = ((opt == `PTM_OPT_RST_HI) && ext_hold_ff) ||
		((opt == `PTM_OPT_RST_LO) && !ext_hold_ff);
	assign edge_rst = ((opt == `PTM_OPT_RST_RISE) && ext_rise) ||
		((opt == `PTM_OPT_RST_FALL) && ext_fall) ||
		((opt == `PTM_OPT_RST_BOTH) && (ext_rise || ext_fall));
	assign rst_ev = lvl_rst || edge_rst;
	assign scaler_clr = wr_count || wr_ctl || rst_ev;

	// ----------------------------------------------------------------
	// Timer clock and prescaler
	// ----------------------------------------------------------------
	assign run = on_bit && !stopped_ff && gate_ok && !lvl_rst;
	// Clock pin rising edge or every system cycle
	assign src_en = run && (ctl_ff[`PTM_CTL_CKSRC] ? (sync_lvl[4] && !ck_prev_ff) : 1'b1);

	ptm_prescale u_pre (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.en_i(src_en),
		.clr_i(scaler_clr),
		.ratio_i(ctl_ff[`PTM_CTL_PRE_HI:`PTM_CTL_PRE_LO]),
		.tick_o(tick)
	);

	assign eq = (count_ff == period_ff);
	assign match = tick && eq;
	assign post_hit = match && (post_ff == ctl1_ff);

	// ----------------------------------------------------------------
	// Next-state of count, postscaler and run state
	// ----------------------------------------------------------------
	// Software write outranks an external reset, which outranks a tick
	always @* begin
		nxt_count = count_ff;
		nxt_post = post_ff;
		nxt_on = on_bit;
		nxt_stopped = stopped_ff;
		if (wr_count) begin
			nxt_count = dat_i[7:0];
		end else if (rst_ev) begin
			nxt_count = `PTM_COUNT_RST;
		end else if (tick) begin
			if (eq) begin
				nxt_count = `PTM_COUNT_RST;
			end else begin
				nxt_count = count_ff + 8'h01;
			end
		end
		if (scaler_clr) begin
			nxt_post = `PTM_POST_ZERO;
		end else if (post_hit) begin
			nxt_post = `PTM_POST_ZERO;
		end else if (match) begin
			nxt_post = post_ff + 5'h01;
		end
		case (maj)
			`PTM_MAJ_ONESHOT: begin
				if (match) begin
					nxt_on = 1'b0;
				end
			end
			`PTM_MAJ_MONO: begin
				if (match) begin
					nxt_stopped = 1'b1;
				end
			end
			default: begin
				nxt_stopped = 1'b0;
			end
		endcase
		// A restart event or a control write releases a monostable stop
		if (rst_ev || wr_ctl) begin
			nxt_stopped = 1'b0;
		end
		if (wr_ctl) begin
			nxt_on = dat_i[`PTM_CTL_ON];
		end
	end

	// ----------------------------------------------------------------
	// Register file and timer state
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			count_ff <= `PTM_COUNT_RST;
			period_ff <= `PTM_PERIOD_RST;
			ctl_ff <= `PTM_BYTE_ZERO;
			ctl1_ff <= `PTM_POST_ZERO;
			halt_ff <= `PTM_POST_ZERO;
			rsel_ff <= 2'h0;
			post_ff <= `PTM_POST_ZERO;
			stopped_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			post_ff <= nxt_post;
			stopped_ff <= nxt_stopped;
			ctl_ff[`PTM_CTL_ON] <= nxt_on;
			if (wr_ctl) begin
				// Control write keeps the count; the scalers and the monostable stop clear
				ctl_ff[`PTM_CTL_ON - 1:0] <= dat_i[`PTM_CTL_ON - 1:0];
			end
			if (wr_byte && (adr_i == `PTM_ADR_PERIOD)) begin
				period_ff <= dat_i[7:0];
			end
			if (wr_byte && (adr_i == `PTM_ADR_CTL1)) begin
				ctl1_ff <= dat_i[`PTM_C1_PS_HI:`PTM_C1_PS_LO];
			end
			if (wr_byte && (adr_i == `PTM_ADR_HALT)) begin
				halt_ff <= dat_i[`PTM_HLT_MAJ_HI:`PTM_HLT_OPT_LO];
			end
			if (wr_byte && (adr_i == `PTM_ADR_RSEL)) begin
				rsel_ff <= dat_i[`PTM_RSEL_HI:`PTM_RSEL_LO];
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	// Unmapped addresses still ack and read as zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= `PTM_WORD_ZERO;
		end else begin
			ack_o <= bus_req;
			if (bus_req && !we_i) begin
				case (adr_i)
					`PTM_ADR_COUNT: dat_o <= {24'h000000, count_ff};
					`PTM_ADR_PERIOD: dat_o <= {24'h000000, period_ff};
					`PTM_ADR_CTL: dat_o <= {24'h000000, ctl_ff};
					`PTM_ADR_CTL1: dat_o <= {27'h0000000, ctl1_ff};
					`PTM_ADR_HALT: dat_o <= {27'h0000000, halt_ff};
					`PTM_ADR_RSEL: dat_o <= {30'h00000000, rsel_ff};
					`PTM_ADR_STAT: dat_o <= {23'h000000, post_ff, ext_hold_ff, stopped_ff, run, eq};
					default: dat_o <= `PTM_WORD_ZERO;
				endcase
			end else begin
				dat_o <= `PTM_WORD_ZERO;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs to other peripherals
	// ----------------------------------------------------------------
	// Postscaled level lasts until the next timer tick, or one system cycle when the timer stops at match; strobes are one system cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			postscaled_pulse_out_o <= 1'b0;
			adc_trigger_o <= 1'b0;
			shutdown_src_o <= 1'b0;
			timer_count_o <= `PTM_COUNT_RST;
			period_match_o <= 1'b0;
			timer_tick_o <= 1'b0;
		end else begin
			if (post_hit) begin
				postscaled_pulse_out_o <= 1'b1;
			end else if (tick || scaler_clr || !run) begin
				postscaled_pulse_out_o <= 1'b0;
			end
			adc_trigger_o <= post_hit;
			shutdown_src_o <= post_hit;
			timer_count_o <= nxt_count;
			period_match_o <= (nxt_count == period_ff);
			timer_tick_o <= tick;
		end
	end

endmodule // ptm_top

`default_nettype wire

// ### dv/ptm_top_asserts.sv
// Checker of the period timer: bus handshake, count steps, output pulses.
// Assumes binding to ptm_top and sight of its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.vh"
module ptm_top_chk (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire postscaled_pulse_out_o,
	input wire adc_trigger_o,
	input wire shutdown_src_o,
	input wire [7:0] timer_count_o
);
	logic [2:0] cw_ff;
	// Recent count writes excuse a jump of the count copy
	always @(posedge clk_i) begin
		if (rst_i) cw_ff <= 3'h0;
		else cw_ff <= {cw_ff[1:0], cyc_i & stb_i & we_i & sel_i[0] & (adr_i == `PTM_ADR_COUNT)};
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack after request");
	AST_ACK_ONE: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside ack");
	AST_RST_CNT: assert property ($past(rst_i) |-> timer_count_o == `PTM_COUNT_RST)
		else $error("count not cleared by reset");
	AST_CNT_STEP: assert property ($changed(timer_count_o) && cw_ff == 3'h0 |->
		(timer_count_o == $past(timer_count_o) + 8'h01 || timer_count_o == 8'h00))
		else $error("count jumped");
	AST_ADC_SHDN: assert property (adc_trigger_o == shutdown_src_o)
		else $error("trigger and shutdown differ");
	AST_ADC_POST: assert property (adc_trigger_o |-> postscaled_pulse_out_o)
		else $error("trigger without postscaled pulse");
endmodule // ptm_top_chk
bind ptm_top ptm_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
	.postscaled_pulse_out_o(postscaled_pulse_out_o), .adc_trigger_o(adc_trigger_o),
	.shutdown_src_o(shutdown_src_o), .timer_count_o(timer_count_o));
`default_nettype wire

// ### dv/ptm_trig_src.sv
// Model of the source on the timer's external reset/gate lines.
// Assumes the timer clock equals the system clock (prescale 1).
`timescale 1ns/1ps
`default_nettype none
module ptm_trig_src (
	input wire logic clk_i,
	input wire logic want_i,
	output logic [3:0] ext_src_o
);
	logic lvl_ff = 1'b0;
	logic [2:0] gap_ff = 3'h0;
	logic [2:0] noise_ff = 3'h5;
	// Level moves only after six quiet ticks, so it stands at least seven; idle lines toggle
	always @(posedge clk_i) begin
		noise_ff <= ~noise_ff;
		if (want_i != lvl_ff && gap_ff == 3'h6) begin
			lvl_ff <= want_i;
			gap_ff <= 3'h0;
		end else if (gap_ff != 3'h6) begin
			gap_ff <= gap_ff + 3'h1;
		end
	end
	assign ext_src_o = {noise_ff, lvl_ff};
endmodule // ptm_trig_src
`default_nettype wire

// ### dv/ptm_top_tb.sv
// Testbench of the period timer: Wishbone register tasks and mode scenarios.
// Assumes ptm_top, the trigger source model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_map.vh"
`define CHK(nm, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		fails++; \
		$display("[ERR] %s exp %0h got %0h", nm, e, g); \
	end \
end
module ptm_top_tb;
	logic clk_i = 1'b0;
	logic ext_ck = 1'b0;
	logic rst_i, cyc_i, stb_i, we_i, dbg_freeze_i, want, ack_o, pso, adc, shd, pm, tick;
	logic [7:0] adr_i, cnt_o;
	logic [3:0] sel_i, ext_src;
	logic [31:0] dat_i, dat_o, rdat;
	logic [4:0] ps [3] = '{5'h00, 5'h02, 5'h01};
	logic [2:0] rt [3] = '{3'h0, 3'h0, 3'h1};
	int gap [3] = '{3, 9, 12};
	int fails = 0;
	int checks = 0;
	int n;
	// ----------------------------------------------------------------
	// Clock, design and trigger source
	// ----------------------------------------------------------------
	always #10 clk_i = ~clk_i;
	ptm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.ext_src_i(ext_src), .ext_clk_i(ext_ck), .dbg_freeze_i(dbg_freeze_i),
		.postscaled_pulse_out_o(pso), .adc_trigger_o(adc), .shutdown_src_o(shd),
		.timer_count_o(cnt_o), .period_match_o(pm), .timer_tick_o(tick));
	ptm_trig_src u_src (.clk_i(clk_i), .want_i(want), .ext_src_o(ext_src));
	task automatic stop_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic tmo(input int k, input int lim);
		if (k >= lim) begin
			fails++;
			stop_test();
		end
	endtask
	// One classic cycle; request held until ack is sampled high
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, 24'h0, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		rdat = dat_o;
		{cyc_i, stb_i, we_i} <= 3'h0;
		tmo(k, 50);
	endtask
	task automatic wait_adc(output int k);
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (adc !== 1'b1 && k < 400);
		tmo(k, 400);
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task automatic held();
		logic [31:0] a;
		wb(`PTM_ADR_COUNT, 1'b0, 8'h00);
		a = rdat;
		wb(`PTM_ADR_COUNT, 1'b0, 8'h00);
		`CHK("held count", a, rdat)
	endtask
	task automatic done(input string s);
		$display("test %s ends", s);
	endtask
	// Main sequence; each block leaves the timer for the next
	initial begin
		{rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'h8, 8'h00, 4'hF, 32'h0};
		dbg_freeze_i = 1'b0;
		want = 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(`PTM_ADR_COUNT, 1'b0, 8'h00);
		`CHK("count", 32'h0, rdat)
		wb(`PTM_ADR_PERIOD, 1'b0, 8'h00);
		`CHK("period", 32'hFF, rdat)
		wb(8'h1C, 1'b0, 8'h00);
		`CHK("unmapped", 32'h0, rdat)
		done("reset");
		wb(`PTM_ADR_PERIOD, 1'b1, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wb(`PTM_ADR_CTL1, 1'b1, {3'h0, ps[i]});
			wb(`PTM_ADR_CTL, 1'b1, {5'h10, rt[i]});
			wait_adc(n);
			wait_adc(n);
			`CHK("pulse gap", gap[i], n)
			`CHK("tick at pulse", 1'b1, tick)
			`CHK("postscaled", 1'b1, pso)
			`CHK("shutdown", 1'b1, shd)
		end
		done("period");
		wb(`PTM_ADR_CTL, 1'b1, 8'h00);
		wb(`PTM_ADR_COUNT, 1'b1, 8'h5A);
		wb(`PTM_ADR_CTL, 1'b1, 8'h00);
		wb(`PTM_ADR_COUNT, 1'b0, 8'h00);
		`CHK("count kept", 32'h5A, rdat)
		`CHK("count out", 8'h5A, cnt_o)
		wb(`PTM_ADR_PERIOD, 1'b1, 8'h5A);
		idle(1);
		`CHK("match out", 1'b1, pm)
		`CHK("tick out", 1'b0, tick)
		done("write");
		wb(`PTM_ADR_CTL1, 1'b1, 8'h00);
		wb(`PTM_ADR_PERIOD, 1'b1, 8'h04);
		wb(`PTM_ADR_HALT, 1'b1, 8'h08);
		wb(`PTM_ADR_COUNT, 1'b1, 8'h00);
		for (int i = 0; i < 2; i++) begin
			wb(`PTM_ADR_CTL, 1'b1, 8'h80);
			wait_adc(n);
			wb(`PTM_ADR_CTL, 1'b0, 8'h00);
			`CHK("oneshot on", 32'h00, rdat)
			held();
		end
		done("oneshot");
		wb(`PTM_ADR_RSEL, 1'b1, 8'h00);
		wb(`PTM_ADR_HALT, 1'b1, 8'h13);
		wb(`PTM_ADR_CTL, 1'b1, 8'h80);
		wait_adc(n);
		wb(`PTM_ADR_CTL, 1'b0, 8'h00);
		`CHK("mono on", 32'h80, rdat)
		held();
		want <= 1'b1;
		wait_adc(n);
		`CHK("restart", 13, n)
		done("mono");
		want <= 1'b0;
		wb(`PTM_ADR_PERIOD, 1'b1, 8'hFF);
		wb(`PTM_ADR_HALT, 1'b1, 8'h01);
		idle(20);
		wb(`PTM_ADR_COUNT, 1'b1, 8'h07);
		wb(`PTM_ADR_CTL, 1'b1, 8'h80);
		idle(8);
		wb(`PTM_ADR_COUNT, 1'b0, 8'h00);
		`CHK("gated", 32'h07, rdat)
		want <= 1'b1;
		idle(20);
		wb(`PTM_ADR_COUNT, 1'b0, 8'h00);
		`CHK("resumed", 1'b1, rdat[7:0] > 8'h07)
		done("gate");
		want <= 1'b0;
		idle(20);
		dbg_freeze_i <= 1'b1;
		wb(`PTM_ADR_HALT, 1'b1, 8'h06);
		want <= 1'b1;
		idle(20);
		wb(`PTM_ADR_COUNT, 1'b0, 8'h00);
		`CHK("frozen", 1'b1, rdat[7:0] != 8'h00)
		dbg_freeze_i <= 1'b0;
		idle(12);
		held();
		`CHK("level reset", 32'h0, rdat)
		done("freeze");
		// Clock pin source: five slow pin rises give five counts
		wb(`PTM_ADR_HALT, 1'b1, 8'h00);
		wb(`PTM_ADR_CTL, 1'b1, 8'h88);
		wb(`PTM_ADR_COUNT, 1'b1, 8'h00);
		repeat (5) begin
			ext_ck <= 1'b1;
			idle(4);
			ext_ck <= 1'b0;
			idle(4);
		end
		idle(8);
		wb(`PTM_ADR_COUNT, 1'b0, 8'h00);
		`CHK("pin clock", 32'h05, rdat)
		done("extclk");
		stop_test();
	end
endmodule // ptm_top_tb
`default_nettype wire
